/* File: src/spi_flash_status_consts.vh */
// Constants for the serial flash status register block.
// Operation
// - Write enable command sets latch; completion clears
// - Status bits one 7:2, two 6:0 non-volatile
// - Suspend, latch, busy are volatile read-only
// - Non-volatile write needs enable, protect bits, pin
// - Volatile shadows govern protection and quad mode
// - Power-up and soft reset reload shadows
// - Volatile enable then write touches shadows and register three only
// - Shadow writes need volatile enable and protection
// - Register three needs volatile enable only, written even when locked
// - Register three configures latency and wrap
// - Reset-enable then reset, on current lane count
// - Parameter table returns fixed sixteenth dword bytes
// - Separate read commands; quad flag second byte
// - No embedded operation while latch clear
`ifndef SPI_FLASH_STATUS_CONSTS_VH
`define SPI_FLASH_STATUS_CONSTS_VH

// Command codes.
`define CMD_WREN      8'h06
`define CMD_WRDI      8'h04
`define CMD_VWREN     8'h50
`define CMD_WRSR      8'h01
`define CMD_RDSR1     8'h05
`define CMD_RDSR2     8'h35
`define CMD_RDSR3     8'h33
`define CMD_DISCOVERABLE_PARAM_TABLE      8'h5a
`define CMD_RSTEN     8'h66
`define CMD_RST       8'h99

// Field positions.
`define SR1_BUSY      0
`define SR1_WEL       1
`define SR1_STATUS_PROTECT_LO      7
`define SR2_STATUS_PROTECT_HI      0
`define SR2_QE        1
`define SR2_CMP       6
`define SR2_SUS       7

// Field masks.
`define SR1_NV_MASK   8'hfc
`define SR2_NV_MASK   8'h7f
`define SR2_VOL_MASK  8'h42
`define SR2_OTP_MASK  8'h3c

// Reset values.
`define SR1_RST       8'h00
`define SR2_RST       8'h04
`define SR3_RST       8'h00

// Lane mode codes.
`define LANE_1        2'h0
`define LANE_2        2'h1
`define LANE_4        2'h2

// Parameter table addresses and data.
`define DISCOVERABLE_PARAM_TABLE_A_3C     24'h00_003c
`define DISCOVERABLE_PARAM_TABLE_A_3D     24'h00_003d
`define DISCOVERABLE_PARAM_TABLE_A_3E     24'h00_003e
`define DISCOVERABLE_PARAM_TABLE_D_3C     8'he8
`define DISCOVERABLE_PARAM_TABLE_D_3D     8'h10
`define DISCOVERABLE_PARAM_TABLE_D_3E     8'hc0
`define DISCOVERABLE_PARAM_TABLE_D_NONE   8'hff

// Non-volatile status write time in system clock cycles.
`define WRSR_CYCLES_DEF 20'h0_03e8

`endif

/* File: src/pin_sync2.v */
// Two-stage synchroniser for pins from outside the system clock.
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
	parameter W = 1
) (
	// Clock and reset.
	input  wire         clk_sys,
	input  wire         rst,
	// Asynchronous inputs and their synchronised copies.
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);

	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;

	// Only the second stage is visible; the first may be metastable.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_r <= {W{1'b1}};
			sync_r <= {W{1'b1}};
		end else begin
			meta_r <= d;
			sync_r <= meta_r;
		end
	end

	assign q = sync_r;

endmodule
`default_nettype wire

/* File: src/spi_flash_status_reg_ctrl.v */
// Status registers, write gating and soft reset of a serial flash.
`timescale 1ns/1ps
`default_nettype none
`include "spi_flash_status_consts.vh"

module spi_flash_status_reg_ctrl #(
	parameter [19:0] WRSR_CYCLES = `WRSR_CYCLES_DEF
) (
	// System clock and reset.
	input  wire       clk_sys,
	input  wire       rst,
	// Serial link pins.
	input  wire       sck,
	input  wire       cs_n,
	input  wire [3:0] io_in,
	output wire [3:0] io_out,
	output wire [3:0] io_oe_n,
	// Operating mode from the device's mode logic.
	input  wire [1:0] lane_mode,
	// Array engine handshake.
	input  wire       op_req,
	input  wire       op_done,
	input  wire       op_busy,
	input  wire       op_suspended,
	output wire       op_start_ok,
	// Live configuration for the rest of the device.
	output wire       status_busy,
	output wire       quad_enable_flag,
	output wire [5:0] prot_cfg,
	output wire [7:0] status_three,
	output wire       soft_reset
);

	localparam [2:0] PH_CMD   = 3'd0;
	localparam [2:0] PH_ADDR  = 3'd1;
	localparam [2:0] PH_DUMMY = 3'd2;
	localparam [2:0] PH_OUT   = 3'd3;
	localparam [2:0] PH_WDATA = 3'd4;
	localparam [2:0] PH_IGN   = 3'd5;

	wire [5:0] pins_s;
	wire       sck_s = pins_s[5];
	wire       cs_s  = pins_s[4];
	wire [3:0] io_s  = pins_s[3:0];

	// Link pins cross into the system clock before any logic reads them.
	pin_sync2 #(
		.W (6)
	) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.d       ({sck, cs_n, io_in}),
		.q       (pins_s)
	);

	reg        sck_d_r;
	reg        cs_d_r;
	reg  [2:0] phase_r;
	reg  [3:0] cnt_r;
	reg  [7:0] rx_r;
	reg  [7:0] tx_r;
	reg  [7:0] cmd_r;
	reg        cmd_ok_r;
	reg  [23:0] addr_r;
	reg  [1:0] addr_n_r;
	reg  [1:0] wr_n_r;
	reg  [7:0] wd1_r;
	reg  [7:0] wd2_r;
	reg  [7:0] wd3_r;
	reg  [7:0] nv1_r;
	reg  [7:0] nv2_r;
	reg  [7:0] sh1_r;
	reg  [7:0] sh2_r;
	reg  [7:0] sr3_r;
	reg        wel_r;
	reg        vwe_r;
	reg        rsten_r;
	reg        wr_busy_r;
	reg  [19:0] wr_cnt_r;
	reg  [7:0] pend1_r;
	reg  [7:0] pend2_r;
	reg  [3:0] io_out_r;
	reg  [3:0] io_oe_n_r;
	reg        op_start_ok_r;
	reg        status_busy_r;
	reg        quad_r;
	reg  [5:0] prot_r;
	reg  [7:0] sr3_out_r;
	reg        soft_reset_r;

	reg  [7:0] rx_nxt;
	reg  [3:0] step;
	reg  [7:0] discoverable_param_table_byte;
	reg  [7:0] nv2_nxt;

	wire sck_rise = sck_s & ~sck_d_r;
	wire sck_fall = ~sck_s & sck_d_r;
	wire cs_end   = cs_s & ~cs_d_r;
	wire active   = ~cs_s;
	wire [3:0] cnt_nxt   = cnt_r + step;
	wire       byte_done = cnt_nxt[3];
	wire       busy      = wr_busy_r | op_busy;
	wire       wp_n      = io_s[2];

	// protect bits plus pin
	// Pin protection only counts while quad mode is off in the shadow.
	wire locked = nv2_r[`SR2_STATUS_PROTECT_HI] | (nv1_r[`SR1_STATUS_PROTECT_LO] & ~sh2_r[`SR2_QE] & ~wp_n);

	// volatile read-only bits
	// Busy, latch and suspend come from live control state, never storage.
	wire [7:0] sr1_view = {sh1_r[7:2], wel_r, busy};
	wire [7:0] sr2_view = {op_suspended, sh2_r[`SR2_CMP], nv2_r[5:2], sh2_r[`SR2_QE], nv2_r[`SR2_STATUS_PROTECT_HI]};

	// lane-dependent bit assembly
	// Commands arrive on as many lanes as the current mode uses.
	always @* begin
		case (lane_mode)
			`LANE_2: begin
				rx_nxt = {rx_r[5:0], io_s[1:0]};
				step   = 4'h2;
			end
			`LANE_4: begin
				rx_nxt = {rx_r[3:0], io_s[3:0]};
				step   = 4'h4;
			end
			default: begin
				rx_nxt = {rx_r[6:0], io_s[0]};
				step   = 4'h1;
			end
		endcase
	end

	// fixed sixteenth dword
	// Only the reset and addressing bytes are held; other bytes read erased.
	always @* begin
		case (addr_r)
			`DISCOVERABLE_PARAM_TABLE_A_3C: discoverable_param_table_byte = `DISCOVERABLE_PARAM_TABLE_D_3C;
			`DISCOVERABLE_PARAM_TABLE_A_3D: discoverable_param_table_byte = `DISCOVERABLE_PARAM_TABLE_D_3D;
			`DISCOVERABLE_PARAM_TABLE_A_3E: discoverable_param_table_byte = `DISCOVERABLE_PARAM_TABLE_D_3E;
			default:    discoverable_param_table_byte = `DISCOVERABLE_PARAM_TABLE_D_NONE;
		endcase
	end

	// lock bits are set-only
	// One-time lock bits can be set but never cleared by a write.
	always @* begin
		nv2_nxt = (pend2_r & `SR2_NV_MASK & ~`SR2_OTP_MASK) |
			((pend2_r | nv2_r) & `SR2_OTP_MASK);
	end

	// Serial front end: edge tracking, phase machine and byte assembly.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sck_d_r   <= 1'b1;
			cs_d_r    <= 1'b1;
			phase_r   <= PH_CMD;
			cnt_r     <= 4'h0;
			rx_r      <= 8'h00;
			tx_r      <= 8'h00;
			cmd_r     <= 8'h00;
			cmd_ok_r  <= 1'b0;
			addr_r    <= 24'h00_0000;
			addr_n_r  <= 2'h0;
			wr_n_r    <= 2'h0;
			wd1_r     <= 8'h00;
			wd2_r     <= 8'h00;
			wd3_r     <= 8'h00;
			io_out_r  <= 4'h0;
			io_oe_n_r <= 4'hf;
		end else begin
			sck_d_r <= sck_s;
			cs_d_r  <= cs_s;
			if (!active) begin
				phase_r   <= PH_CMD;
				cnt_r     <= 4'h0;
				cmd_ok_r  <= cs_end ? cmd_ok_r : 1'b0;
				addr_n_r  <= 2'h0;
				wr_n_r    <= cs_end ? wr_n_r : 2'h0;
				io_oe_n_r <= 4'hf;
			end else if (sck_rise) begin
				rx_r  <= rx_nxt;
				cnt_r <= byte_done ? 4'h0 : cnt_nxt;
				if (byte_done) begin
					case (phase_r)
						PH_CMD: begin
							cmd_r    <= rx_nxt;
							cmd_ok_r <= 1'b1;
							case (rx_nxt)
								`CMD_RDSR1: begin
									tx_r    <= sr1_view;
									phase_r <= PH_OUT;
								end
								`CMD_RDSR2: begin
									tx_r    <= sr2_view;
									phase_r <= PH_OUT;
								end
								`CMD_RDSR3: begin
									tx_r    <= sr3_r;
									phase_r <= PH_OUT;
								end
								`CMD_DISCOVERABLE_PARAM_TABLE:  phase_r <= PH_ADDR;
								`CMD_WRSR:  phase_r <= PH_WDATA;
								default:    phase_r <= PH_IGN;
							endcase
						end
						PH_ADDR: begin
							addr_r   <= {addr_r[15:0], rx_nxt};
							addr_n_r <= addr_n_r + 2'h1;
							if (addr_n_r == 2'h2) begin
								phase_r <= PH_DUMMY;
							end
						end
						PH_DUMMY: begin
							tx_r    <= discoverable_param_table_byte;
							addr_r  <= addr_r + 24'h00_0001;
							phase_r <= PH_OUT;
						end
						PH_OUT: begin
							// Status reads repeat the live value until the frame ends.
							case (cmd_r)
								`CMD_RDSR1: tx_r <= sr1_view;
								`CMD_RDSR2: tx_r <= sr2_view;
								`CMD_RDSR3: tx_r <= sr3_r;
								default: begin
									tx_r   <= discoverable_param_table_byte;
									addr_r <= addr_r + 24'h00_0001;
								end
							endcase
						end
						PH_WDATA: begin
							case (wr_n_r)
								2'h0:    wd1_r <= rx_nxt;
								2'h1:    wd2_r <= rx_nxt;
								2'h2:    wd3_r <= rx_nxt;
								default: wd3_r <= wd3_r;
							endcase
							if (wr_n_r != 2'h3) begin
								wr_n_r <= wr_n_r + 2'h1;
							end
						end
						default: phase_r <= phase_r;
					endcase
				end
			end else if (sck_fall && phase_r == PH_OUT) begin
				// Data changes on the falling edge so the host samples it stable.
				case (lane_mode)
					`LANE_2: begin
						io_out_r  <= {2'b00, tx_r[7:6]};
						io_oe_n_r <= 4'hc;
						tx_r      <= {tx_r[5:0], 2'b00};
					end
					`LANE_4: begin
						io_out_r  <= tx_r[7:4];
						io_oe_n_r <= 4'h0;
						tx_r      <= {tx_r[3:0], 4'h0};
					end
					default: begin
						io_out_r  <= {2'b00, tx_r[7], 1'b0};
						io_oe_n_r <= 4'hd;
						tx_r      <= {tx_r[6:0], 1'b0};
					end
				endcase
			end
		end
	end

	// Command execution at frame end, status storage and write timing.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			nv1_r        <= `SR1_RST;
			nv2_r        <= `SR2_RST;
			sh1_r        <= `SR1_RST;
			sh2_r        <= `SR2_RST;
			sr3_r        <= `SR3_RST;
			wel_r        <= 1'b0;
			vwe_r        <= 1'b0;
			rsten_r      <= 1'b0;
			wr_busy_r    <= 1'b0;
			wr_cnt_r     <= 20'h0_0000;
			pend1_r      <= 8'h00;
			pend2_r      <= 8'h00;
			soft_reset_r <= 1'b0;
		end else begin
			soft_reset_r <= 1'b0;
			if (op_done) begin
				wel_r <= 1'b0;
			end
			if (wr_busy_r) begin
				wr_cnt_r <= wr_cnt_r - 20'h0_0001;
				if (wr_cnt_r == 20'h0_0001) begin
					wr_busy_r <= 1'b0;
					wel_r     <= 1'b0;
					nv1_r     <= (nv1_r & ~`SR1_NV_MASK) | (pend1_r & `SR1_NV_MASK);
					nv2_r     <= nv2_nxt;
					sh1_r     <= pend1_r & `SR1_NV_MASK;
					sh2_r     <= nv2_nxt & `SR2_VOL_MASK;
				end
			end
			if (cs_end) begin
				// Enable prefixes only reach the very next frame.
				vwe_r   <= 1'b0;
				rsten_r <= 1'b0;
			end
			// Partial bytes or a frame without a command do nothing.
			if (cs_end && cmd_ok_r && cnt_r == 4'h0 && !wr_busy_r) begin
				case (cmd_r)
					`CMD_WREN:  wel_r   <= 1'b1;
					`CMD_WRDI:  wel_r   <= 1'b0;
					`CMD_VWREN: vwe_r   <= 1'b1;
					`CMD_RSTEN: rsten_r <= 1'b1;
					`CMD_RST: begin
						if (rsten_r) begin
							sh1_r        <= nv1_r & `SR1_NV_MASK;
							sh2_r        <= nv2_r & `SR2_VOL_MASK;
							sr3_r        <= `SR3_RST;
							wel_r        <= 1'b0;
							soft_reset_r <= 1'b1;
						end
					end
					`CMD_WRSR: begin
						if (wr_n_r != 2'h0 && vwe_r) begin
							if (!locked) begin
								sh1_r <= wd1_r & `SR1_NV_MASK;
								if (wr_n_r != 2'h1) begin
									sh2_r <= wd2_r & `SR2_VOL_MASK;
								end
							end
							if (wr_n_r == 2'h3) begin
								sr3_r <= wd3_r;
							end
						end else if (wr_n_r != 2'h0 && wel_r && !locked) begin
							pend1_r   <= wd1_r;
							pend2_r   <= (wr_n_r == 2'h1) ? nv2_r : wd2_r;
							wr_busy_r <= 1'b1;
							wr_cnt_r  <= WRSR_CYCLES;
						end
					end
					default: wel_r <= wel_r;
				endcase
			end
		end
	end

	// Registered copies of the live state for the rest of the device.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			op_start_ok_r <= 1'b0;
			status_busy_r <= 1'b0;
			quad_r        <= 1'b0;
			prot_r        <= 6'h00;
			sr3_out_r     <= `SR3_RST;
		end else begin
			op_start_ok_r <= op_req & wel_r & ~busy;
			status_busy_r <= busy;
			quad_r        <= sh2_r[`SR2_QE];
			prot_r        <= {sh2_r[`SR2_CMP], sh1_r[6:2]};
			sr3_out_r     <= sr3_r;
		end
	end

	assign io_out           = io_out_r;
	assign io_oe_n          = io_oe_n_r;
	assign op_start_ok      = op_start_ok_r;
	assign status_busy      = status_busy_r;
	assign quad_enable_flag = quad_r;
	assign prot_cfg         = prot_r;
	assign status_three     = sr3_out_r;
	assign soft_reset       = soft_reset_r;

endmodule
`default_nettype wire

/* File: tb/spi_flash_status_checker.sv */
// Concurrent checks on the status block's ports.
`timescale 1ns/1ps
`default_nettype none
module spi_flash_status_checker #(
	parameter [19:0] WRSR_CYCLES = 20'h0_03e8
) (
	// Clock and reset.
	input wire logic       clk_sys,
	input wire logic       rst,
	// Link and engine inputs.
	input wire logic       cs_n,
	input wire logic       op_req,
	input wire logic       op_busy,
	// Observed outputs.
	input wire logic [3:0] io_oe_n,
	input wire logic       op_start_ok,
	input wire logic       status_busy,
	input wire logic       quad_enable_flag,
	input wire logic [5:0] prot_cfg,
	input wire logic       soft_reset
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// A status write busy period starts with the engine idle.
	sequence nv_start;
		$rose(status_busy) && !$past(op_busy);
	endsequence
	sequence nv_hold;
		status_busy [*8];
	endsequence
	start_gate_a: assert property (op_start_ok |-> $past(op_req) && !$past(op_busy))
		else $error("start without request");
	busy_follow_a: assert property ($past(op_busy) |-> status_busy)
		else $error("busy not shown");
	nv_busy_a: assert property (nv_start |-> nv_hold)
		else $error("status write busy too short");
	sreset_pulse_a: assert property (soft_reset |=> !soft_reset)
		else $error("reset pulse too long");
	sreset_idle_a: assert property (soft_reset |-> cs_n)
		else $error("reset inside frame");
	release_a: assert property ($rose(cs_n) |-> ##[1:8] io_oe_n == 4'hf)
		else $error("lanes not released");
	quad_hold_a: assert property ($changed(quad_enable_flag) |-> cs_n)
		else $error("quad flag moved in frame");
	prot_hold_a: assert property ($changed(prot_cfg) |-> cs_n)
		else $error("protection moved in frame");
endmodule
bind spi_flash_status_reg_ctrl spi_flash_status_checker #(.WRSR_CYCLES(WRSR_CYCLES)) chk (
	.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .op_req(op_req), .op_busy(op_busy),
	.io_oe_n(io_oe_n), .op_start_ok(op_start_ok), .status_busy(status_busy),
	.quad_enable_flag(quad_enable_flag), .prot_cfg(prot_cfg), .soft_reset(soft_reset)
);
`default_nettype wire

/* File: tb/spi_host_model.sv */
// Host side of the serial link: one, two or four lanes, mode 0.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// Link pins.
	output logic       sck,
	output logic       cs_n,
	output logic [3:0] io_in,
	input  wire  [3:0] io_out,
	// Lane count shared with the block under test.
	input  wire  [1:0] lane_mode
);
	logic [7:0] rx_buf [0:7];
	// Clock idles low; write-protect pin held high.
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		io_in = 4'hc;
	end
	// msb first framing
	// Read bits are taken just before the next fall, where they still stand.
	// Read data is only meaningful with a single lane; wider modes send commands.
	task automatic frame(input logic [63:0] tx, input int n);
		logic [63:0] sh;
		int         w;
		sh = tx;
		w = (lane_mode == 2'h2) ? 4 : ((lane_mode == 2'h1) ? 2 : 1);
		cs_n = 1'b0;
		#40;
		for (int k = 0; k < n; k++) begin
			for (int i = 7; i >= 0; i -= w) begin
				case (lane_mode)
					2'h1: io_in[1:0] = sh[63:62];
					2'h2: io_in = sh[63:60];
					default: io_in[0] = sh[63];
				endcase
				sh = sh << w;
				#40 sck = 1'b1;
				#40 rx_buf[k][i] = io_out[1];
				sck = 1'b0;
			end
		end
		#40 cs_n = 1'b1;
		// Write-protect pin returns high; the data lane shows the inverse.
		io_in = {3'b110, ~io_in[0]};
		#160;
	endtask
endmodule
`default_nettype wire

/* File: tb/spi_flash_status_reg_ctrl_tb_top.sv */
// Self-checking bench for the status register block.
`timescale 1ns/1ps
`default_nettype none
module spi_flash_status_reg_ctrl_tb_top;
	logic       clk_sys;
	logic       rst;
	logic       sck;
	logic       cs_n;
	logic [3:0] io_in;
	logic [3:0] io_out;
	logic [3:0] io_oe_n;
	logic       op_req;
	logic       op_done;
	logic       op_busy;
	logic       op_suspended;
	logic       op_start_ok;
	logic       status_busy;
	logic       quad_enable_flag;
	logic [5:0] prot_cfg;
	logic [7:0] status_three;
	logic       soft_reset;
	logic [1:0] lane_sel;
	logic [7:0] rst_pulses = 8'h00;
	int         error_cnt;
	int         total_checks;

	// Short status write time keeps the run brief.
	spi_flash_status_reg_ctrl #(.WRSR_CYCLES(20'h0_0014)) uut (
		.clk_sys(clk_sys), .rst(rst), .sck(sck), .cs_n(cs_n), .io_in(io_in),
		.io_out(io_out), .io_oe_n(io_oe_n), .lane_mode(lane_sel), .op_req(op_req),
		.op_done(op_done), .op_busy(op_busy), .op_suspended(op_suspended),
		.op_start_ok(op_start_ok), .status_busy(status_busy),
		.quad_enable_flag(quad_enable_flag), .prot_cfg(prot_cfg),
		.status_three(status_three), .soft_reset(soft_reset)
	);
	spi_host_model host (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .lane_mode(lane_sel));

	// System clock.
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// The reset pulse lasts one cycle, so it is counted here.
	always @(posedge clk_sys) begin
		if (soft_reset === 1'b1) rst_pulses <= rst_pulses + 8'h01;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic send(input logic [63:0] tx, input int n);
		tick(1);
		host.frame(tx, n);
	endtask
	task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
		send({cmd, 56'h0}, 2);
		check(host.rx_buf[1], exp);
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 200 && status_busy !== 1'b0; i++) tick(1);
		if (i == 200) begin
			error_cnt++;
			complete_run();
		end
	endtask

	// Reset values and the suspend bit.
	task automatic t_reset();
		tick(1);
		op_suspended = 1'b1;
		rd_chk(8'h05, 8'h00);
		rd_chk(8'h35, 8'h84);
		rd_chk(8'h33, 8'h00);
		tick(1);
		op_suspended = 1'b0;
	endtask
	// Refused write, then the non-volatile path.
	task automatic t_nv_write();
		send(64'h011c_0200_0000_0000, 3);
		check(status_busy, 1'b0);
		rd_chk(8'h05, 8'h00);
		send(64'h0600_0000_0000_0000, 1);
		send(64'h011c_0200_0000_0000, 3);
		check(status_busy, 1'b1);
		wait_idle();
		rd_chk(8'h05, 8'h1c);
		rd_chk(8'h35, 8'h06);
		check(quad_enable_flag, 1'b1);
		check(prot_cfg, 6'h07);
	endtask
	// Start gating by the latch and busy display.
	task automatic t_op();
		tick(1);
		op_req = 1'b1;
		tick(1);
		op_req = 1'b0;
		check(op_start_ok, 1'b0);
		send(64'h0600_0000_0000_0000, 1);
		rd_chk(8'h05, 8'h1e);
		tick(1);
		op_req = 1'b1;
		tick(1);
		op_req = 1'b0;
		check(op_start_ok, 1'b1);
		op_done = 1'b1;
		tick(1);
		op_done = 1'b0;
		rd_chk(8'h05, 8'h1c);
		tick(1);
		op_busy = 1'b1;
		tick(2);
		check(status_busy, 1'b1);
		rd_chk(8'h05, 8'h1d);
		tick(1);
		op_busy = 1'b0;
	endtask
	// Volatile write reaches shadows and register three.
	task automatic t_volatile();
		send(64'h5000_0000_0000_0000, 1);
		send(64'h0100_005a_0000_0000, 4);
		check(status_busy, 1'b0);
		check(prot_cfg, 6'h00);
		check(quad_enable_flag, 1'b0);
		check(status_three, 8'h5a);
	endtask
	// A broken pair does nothing; a whole pair reloads shadows.
	task automatic t_soft_reset();
		logic [7:0] base;
		base = rst_pulses;
		send(64'h6600_0000_0000_0000, 1);
		send(64'h0500_0000_0000_0000, 1);
		send(64'h9900_0000_0000_0000, 1);
		check(rst_pulses - base, 8'h00);
		check(prot_cfg, 6'h00);
		send(64'h6600_0000_0000_0000, 1);
		send(64'h9900_0000_0000_0000, 1);
		check(rst_pulses - base, 8'h01);
		check(prot_cfg, 6'h07);
		check(quad_enable_flag, 1'b1);
	endtask
	// Shadow write and reset pair on two and on four lanes.
	task automatic t_lanes();
		logic [7:0] base;
		for (int m = 1; m < 3; m++) begin
			lane_sel = (m == 1) ? 2'h1 : 2'h2;
			send(64'h5000_0000_0000_0000, 1);
			send(64'h0100_0000_0000_0000, 3);
			check(prot_cfg, 6'h00);
			check(quad_enable_flag, 1'b0);
			base = rst_pulses;
			send(64'h6600_0000_0000_0000, 1);
			send(64'h9900_0000_0000_0000, 1);
			check(rst_pulses - base, 8'h01);
			check(prot_cfg, 6'h07);
		end
		tick(1);
		lane_sel = 2'h0;
	endtask
	// Parameter table bytes of the sixteenth dword.
	task automatic t_table();
		send(64'h5a00_003c_0000_0000, 8);
		check(host.rx_buf[5], 8'he8);
		check(host.rx_buf[6], 8'h10);
		check(host.rx_buf[7], 8'hc0);
	endtask

	// Main sequence.
	initial begin
		error_cnt = 0;
		total_checks = 0;
		rst = 1'b1;
		op_req = 1'b0;
		op_done = 1'b0;
		op_busy = 1'b0;
		op_suspended = 1'b0;
		lane_sel = 2'h0;
		tick(12);
		rst = 1'b0;
		tick(4);
		t_reset();
		t_nv_write();
		t_op();
		t_volatile();
		t_soft_reset();
		t_lanes();
		t_table();
		complete_run();
	end
endmodule
`default_nettype wire
